// >>> core/gpio_clk_pkg.sv
`default_nettype none
package gpio_clk_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_DRIVE = 8'h65;
  localparam logic [7:0] OFS_DIR = 8'h66;
  localparam logic [7:0] OFS_PINS = 8'h67;
  localparam logic [7:0] OFS_CLKGATE = 8'h68;
  localparam logic [7:0] OFS_CAUSE = 8'h6a;
  localparam logic [7:0] OFS_CAUSE_MASK = 8'h6b;
  // reset values
  localparam logic [7:0] RST_DRIVE = 8'h00;
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [15:0] RST_CLKGATE = 16'h0000;
  localparam logic [7:0] RST_CAUSE = 8'h00;
  localparam logic [7:0] RST_CAUSE_MASK = 8'h00;
  // field positions
  localparam int HIGH_LSB = 4;
  localparam int LOW_LSB = 0;
  localparam int CAUSE_LSB = 1;
  localparam int PAIR_OUTPUTS = 4;
  localparam logic [15:0] CLKGATE_WMASK = 16'h3fff;
  localparam logic [1:0] PAIR_OFF = 2'h3;
endpackage
`default_nettype wire

// >>> core/gpio_and_clock_out_regs.sv
// Strobed register access was chosen for this implementation.
`default_nettype none
// Contract
// - both drive bits set: terminal goes low
// - input terminals stay undriven
// - drive bits 7..4 set terminals high
// - drive bits 3..0 set terminals low
// - reset: all terminals inputs, registers zero
// - both direction bits set: terminal is input
// - direction bits 7..4 make terminals outputs
// - direction bits 3..0 make terminals inputs
// - pin state read returns levels in 7..4
// - pin state low nibble reads zero
// - clock gating bits 15..14 read zero
// - bits 13..8 hold outputs 9..4 high
// - two-bit field 11 holds outputs 3..0 high
// - clock gating resets to zero, all run
// - cause register: bits 6..1 write-one-to-clear, reset zero
// - cause bits 6..1 map six error events
module gpio_and_clock_out_regs
  import gpio_clk_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic general_io_pin_0_in,
  output logic general_io_pin_0_out,
  output logic general_io_pin_0_oe,
  input wire logic general_io_pin_1_in,
  output logic general_io_pin_1_out,
  output logic general_io_pin_1_oe,
  input wire logic general_io_pin_2_in,
  output logic general_io_pin_2_out,
  output logic general_io_pin_2_oe,
  input wire logic general_io_pin_3_in,
  output logic general_io_pin_3_out,
  output logic general_io_pin_3_oe,
  output logic sec_clock_output_0,
  output logic sec_clock_output_1,
  output logic sec_clock_output_2,
  output logic sec_clock_output_3,
  output logic sec_clock_output_4,
  output logic sec_clock_output_5,
  output logic sec_clock_output_6,
  output logic sec_clock_output_7,
  output logic sec_clock_output_8,
  output logic sec_clock_output_9,
  input wire logic dread_timeout_evt,
  input wire logic dwrite_timeout_evt,
  input wire logic pw_master_abort_evt,
  input wire logic pw_target_abort_evt,
  input wire logic pw_timeout_evt,
  input wire logic pw_parity_evt,
  output logic irq
);

  typedef struct packed {
    logic [7:0] drive;
    logic [7:0] dir;
    logic [3:0] level;
    logic [3:0] is_out;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [3:0] pin_state;
    logic [15:0] clkgate;
    logic [7:0] cause;
    logic [7:0] cause_mask;
    logic [15:0] rdata;
    logic phase;
    logic [9:0] clk_out;
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
    logic irq;
  } state_s;

  state_s st;
  state_s next_st;
  logic [3:0] pins_in;
  logic [5:0] events;

  // a write or read aimed at one offset
  function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] ofs);
    return wr && (a == ofs);
  endfunction

  // decides whether clock output n is stopped
  function automatic logic clk_stopped(input logic [15:0] g, input int n);
    logic res;
    res = 1'b0;
    if (n < PAIR_OUTPUTS) begin
      res = (g[2*n +: 2] == PAIR_OFF);
    end else begin
      res = g[n + PAIR_OUTPUTS];
    end
    return res;
  endfunction

  assign pins_in = {general_io_pin_3_in, general_io_pin_2_in, general_io_pin_1_in,
                    general_io_pin_0_in};
  // cause bit 6 first, bit 1 last
  assign events = {dread_timeout_evt, dwrite_timeout_evt, pw_master_abort_evt,
                   pw_target_abort_evt, pw_timeout_evt, pw_parity_evt};

  // next-state logic for the whole block
  always_comb begin
    logic [3:0] hi;
    logic [3:0] lo;
    logic [3:0] oe_set;
    logic [3:0] ie_set;
    logic [7:0] cause_clr;
    hi = '0;
    lo = '0;
    oe_set = '0;
    ie_set = '0;
    cause_clr = '0;
    next_st = st;

    // register writes; drive and direction stored as written so reads echo them
    if (wr_hit(reg_wr, reg_addr, OFS_DRIVE)) begin
      next_st.drive = reg_wdata[7:0];
      hi = reg_wdata[HIGH_LSB +: 4];
      lo = reg_wdata[LOW_LSB +: 4];
    end else if (wr_hit(reg_wr, reg_addr, OFS_DIR)) begin
      next_st.dir = reg_wdata[7:0];
      oe_set = reg_wdata[HIGH_LSB +: 4];
      ie_set = reg_wdata[LOW_LSB +: 4];
    end else if (wr_hit(reg_wr, reg_addr, OFS_CLKGATE)) begin
      next_st.clkgate = reg_wdata & CLKGATE_WMASK;
    end else if (wr_hit(reg_wr, reg_addr, OFS_CAUSE)) begin
      cause_clr = reg_wdata[7:0];
    end else if (wr_hit(reg_wr, reg_addr, OFS_CAUSE_MASK)) begin
      next_st.cause_mask = {1'b0, reg_wdata[6:1], 1'b0};
    end

    // a zero bit leaves the latched level alone; low overrides high
    next_st.level = (st.level | hi) & ~lo;
    // same for direction; input overrides output
    next_st.is_out = (st.is_out | oe_set) & ~ie_set;

    // pin drive derived from next values so it follows the write by one edge
    next_st.pin_oe = next_st.is_out;
    next_st.pin_out = next_st.level & next_st.is_out;

    // three-stage sampling; accept a change once stages two and three agree
    next_st.sync1 = pins_in;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    for (int i = 0; i < 4; i++) begin
      if (st.sync2[i] == st.sync3[i]) begin
        next_st.pin_state[i] = st.sync3[i];
      end
    end

    // sticky causes: a same-cycle event beats the clear
    next_st.cause = ((st.cause & ~cause_clr) | {1'b0, events, 1'b0})
                    & {1'b0, 6'h3f, 1'b0};
    next_st.irq = |(next_st.cause & next_st.cause_mask);

    // secondary clocks: half core rate, stopped outputs parked high
    next_st.phase = ~st.phase;
    for (int n = 0; n < 10; n++) begin
      next_st.clk_out[n] = clk_stopped(next_st.clkgate, n) ? 1'b1 : next_st.phase;
    end

    // read data valid only in the cycle after the strobe
    next_st.rdata = '0;
    if (reg_rd) begin
      if (reg_addr == OFS_DRIVE) begin
        next_st.rdata = {8'h00, st.drive};
      end else if (reg_addr == OFS_DIR) begin
        next_st.rdata = {8'h00, st.dir};
      end else if (reg_addr == OFS_PINS) begin
        next_st.rdata = {8'h00, st.pin_state, 4'h0};
      end else if (reg_addr == OFS_CLKGATE) begin
        next_st.rdata = st.clkgate & CLKGATE_WMASK;
      end else if (reg_addr == OFS_CAUSE) begin
        next_st.rdata = {8'h00, st.cause};
      end else if (reg_addr == OFS_CAUSE_MASK) begin
        next_st.rdata = {8'h00, st.cause_mask};
      end
    end
  end

  // single state register; reset leaves every terminal an input
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st <= '0;
      st.drive <= RST_DRIVE;
      st.dir <= RST_DIR;
      st.clkgate <= RST_CLKGATE;
      st.cause <= RST_CAUSE;
      st.cause_mask <= RST_CAUSE_MASK;
    end else begin
      st <= next_st;
    end
  end

  // outputs are flop bits
  assign reg_rdata = st.rdata;
  assign irq = st.irq;
  assign general_io_pin_0_out = st.pin_out[0];
  assign general_io_pin_1_out = st.pin_out[1];
  assign general_io_pin_2_out = st.pin_out[2];
  assign general_io_pin_3_out = st.pin_out[3];
  assign general_io_pin_0_oe = st.pin_oe[0];
  assign general_io_pin_1_oe = st.pin_oe[1];
  assign general_io_pin_2_oe = st.pin_oe[2];
  assign general_io_pin_3_oe = st.pin_oe[3];
  assign sec_clock_output_0 = st.clk_out[0];
  assign sec_clock_output_1 = st.clk_out[1];
  assign sec_clock_output_2 = st.clk_out[2];
  assign sec_clock_output_3 = st.clk_out[3];
  assign sec_clock_output_4 = st.clk_out[4];
  assign sec_clock_output_5 = st.clk_out[5];
  assign sec_clock_output_6 = st.clk_out[6];
  assign sec_clock_output_7 = st.clk_out[7];
  assign sec_clock_output_8 = st.clk_out[8];
  assign sec_clock_output_9 = st.clk_out[9];

  // checks on the pins, reset state, clock gating, causes and register echo
  property p_low_wins;
    @(posedge core_clk) disable iff (!rstn)
      wr_hit(reg_wr, reg_addr, OFS_DRIVE) && reg_wdata[4] && reg_wdata[0]
      |=> !general_io_pin_0_out;
  endproperty
  a_low_wins: assert property (p_low_wins) else $error("low drive did not win");

  property p_input_undriven;
    @(posedge core_clk) disable iff (!rstn)
      wr_hit(reg_wr, reg_addr, OFS_DIR) && reg_wdata[1]
      |=> !general_io_pin_1_oe && !general_io_pin_1_out;
  endproperty
  a_input_undriven: assert property (p_input_undriven) else $error("input driven");

  property p_drive_high;
    @(posedge core_clk) disable iff (!rstn)
      wr_hit(reg_wr, reg_addr, OFS_DRIVE) && reg_wdata[7] && !reg_wdata[3]
      && general_io_pin_3_oe && !reg_rd ##1 !reg_wr[*2] |-> general_io_pin_3_out;
  endproperty
  a_drive_high: assert property (p_drive_high) else $error("pin 3 not driven high");

  property p_drive_low;
    @(posedge core_clk) disable iff (!rstn)
      wr_hit(reg_wr, reg_addr, OFS_DRIVE) && reg_wdata[3] |=> !general_io_pin_3_out;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("pin 3 not driven low");

  property p_reset_inputs;
    @(posedge core_clk) !rstn |=> st.pin_oe == 4'h0 && st.dir == RST_DIR
      && st.drive == RST_DRIVE && st.clkgate == RST_CLKGATE;
  endproperty
  a_reset_inputs: assert property (p_reset_inputs) else $error("bad reset state");

  property p_dir_both;
    @(posedge core_clk) disable iff (!rstn)
      wr_hit(reg_wr, reg_addr, OFS_DIR) && reg_wdata[4] && reg_wdata[0]
      |=> !general_io_pin_0_oe;
  endproperty
  a_dir_both: assert property (p_dir_both) else $error("input enable did not win");

  property p_dir_out;
    @(posedge core_clk) disable iff (!rstn)
      wr_hit(reg_wr, reg_addr, OFS_DIR) && reg_wdata[4] && !reg_wdata[0]
      |=> general_io_pin_0_oe [*1] ##1 (general_io_pin_0_oe || $past(reg_wr));
  endproperty
  a_dir_out: assert property (p_dir_out) else $error("pin 0 not an output");

  property p_pin_read;
    @(posedge core_clk) disable iff (!rstn)
      reg_rd && reg_addr == OFS_PINS
      |=> reg_rdata[3:0] == 4'h0 && reg_rdata[15:8] == 8'h00
      && reg_rdata[7:4] == $past(st.pin_state);
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("pin state read wrong");

  property p_clk_read;
    @(posedge core_clk) disable iff (!rstn)
      reg_rd && reg_addr == OFS_CLKGATE |=> reg_rdata[15:14] == 2'h0;
  endproperty
  a_clk_read: assert property (p_clk_read) else $error("reserved clock bits set");

  property p_single_stop;
    @(posedge core_clk) disable iff (!rstn)
      st.clkgate[8] && $stable(st.clkgate) |-> sec_clock_output_4;
  endproperty
  a_single_stop: assert property (p_single_stop) else $error("output 4 not held high");

  property p_pair_run;
    @(posedge core_clk) disable iff (!rstn)
      $past(rstn) && st.clkgate[1:0] != PAIR_OFF && $past(st.clkgate[1:0]) != PAIR_OFF
      |-> sec_clock_output_0 != $past(sec_clock_output_0);
  endproperty
  a_pair_run: assert property (p_pair_run) else $error("output 0 not toggling");

  property p_set_wins;
    @(posedge core_clk) disable iff (!rstn)
      pw_parity_evt && wr_hit(reg_wr, reg_addr, OFS_CAUSE) && reg_wdata[1]
      |=> st.cause[1] && !st.cause[0] && !st.cause[7];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("cause event lost");

  property p_cause_sticky;
    @(posedge core_clk) disable iff (!rstn)
      st.cause[6] && !wr_hit(reg_wr, reg_addr, OFS_CAUSE) |=> st.cause[6];
  endproperty
  a_cause_sticky: assert property (p_cause_sticky) else $error("cause bit dropped");

  property p_echo;
    @(posedge core_clk) disable iff (!rstn)
      wr_hit(reg_wr, reg_addr, OFS_DRIVE) ##1 (reg_rd && reg_addr == OFS_DRIVE && !reg_wr)
      |=> reg_rdata[7:0] == $past(reg_wdata[7:0], 2);
  endproperty
  a_echo: assert property (p_echo) else $error("drive register echo wrong");

  // checks on the clock outputs; the running check skips the first edge after reset
  // because the outputs leave reset low and only start toggling then
  property p_pair_stop;
    @(posedge core_clk) disable iff (!rstn)
      st.clkgate[7:6] == PAIR_OFF |-> sec_clock_output_3;
  endproperty
  a_pair_stop: assert property (p_pair_stop) else $error("output 3 not held");

  property p_single_run;
    @(posedge core_clk) disable iff (!rstn)
      $past(rstn) && !st.clkgate[13] && !$past(st.clkgate[13])
      |-> sec_clock_output_9 != $past(sec_clock_output_9);
  endproperty
  a_single_run: assert property (p_single_run) else $error("output 9 stuck");

  // checks on the cause register, the interrupt and the read port
  property p_cause_rsvd;
    @(posedge core_clk) disable iff (!rstn)
      !st.cause[7] && !st.cause[0];
  endproperty
  a_cause_rsvd: assert property (p_cause_rsvd) else $error("reserved bit set");

  property p_event_sets;
    @(posedge core_clk) disable iff (!rstn)
      |events |=> (st.cause[6:1] & $past(events)) == $past(events);
  endproperty
  a_event_sets: assert property (p_event_sets) else $error("cause not set");

  property p_cause_clear;
    @(posedge core_clk) disable iff (!rstn)
      wr_hit(reg_wr, reg_addr, OFS_CAUSE) && reg_wdata[6] && !dread_timeout_evt
      |=> !st.cause[6];
  endproperty
  a_cause_clear: assert property (p_cause_clear) else $error("cause not cleared");

  // a mask write in the same cycle may legally hide the event
  property p_irq_raise;
    @(posedge core_clk) disable iff (!rstn)
      |(events & st.cause_mask[6:1]) && !wr_hit(reg_wr, reg_addr, OFS_CAUSE_MASK)
      |=> irq;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("irq not raised");

  property p_rdata_idle;
    @(posedge core_clk) disable iff (!rstn)
      !reg_rd |=> reg_rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");

  // main scenarios
  c_pin_output: cover property (@(posedge core_clk) disable iff (!rstn)
    general_io_pin_2_oe && general_io_pin_2_out);
  c_clk_stopped: cover property (@(posedge core_clk) disable iff (!rstn)
    st.clkgate[7:6] == PAIR_OFF);
  c_irq: cover property (@(posedge core_clk) disable iff (!rstn) irq);
  c_set_clear: cover property (@(posedge core_clk) disable iff (!rstn)
    dread_timeout_evt && wr_hit(reg_wr, reg_addr, OFS_CAUSE));
  c_echo: cover property (@(posedge core_clk) disable iff (!rstn)
    wr_hit(reg_wr, reg_addr, OFS_DRIVE) ##1 (reg_rd && reg_addr == OFS_DRIVE));

endmodule
`default_nettype wire

// >>> sim/board_model.sv
`default_nettype none
module board_model (
  input wire logic [3:0] dev_out,
  input wire logic [3:0] dev_oe,
  input wire logic [3:0] board_lvl,
  output logic [3:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // board drives only where the bridge lets go, so no contention
  assign pin_level = (dev_oe & dev_out) | (~dev_oe & board_lvl);
endmodule
`default_nettype wire

// >>> sim/testbench.sv
`default_nettype none
module testbench
  import gpio_clk_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [3:0] board_lvl = 4'h0;
  logic [5:0] evt = 6'h00;
  logic [15:0] reg_rdata;
  logic [3:0] p_out, p_oe, p_in;
  logic [9:0] sclk;
  logic irq;
  int failures = 0;
  int tests_run = 0;
  // reference state kept by the bench
  logic [3:0] m_lvl, m_oe;
  logic [7:0] m_drive, m_dir, m_cause, m_mask;
  logic [15:0] m_gate;
  logic [7:0] edge_v [6] = '{8'hff, 8'hf0, 8'hf0, 8'hff, 8'h00, 8'h00};

  gpio_and_clock_out_regs dut_u (
    .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .general_io_pin_0_in(p_in[0]), .general_io_pin_0_out(p_out[0]), .general_io_pin_0_oe(p_oe[0]),
    .general_io_pin_1_in(p_in[1]), .general_io_pin_1_out(p_out[1]), .general_io_pin_1_oe(p_oe[1]),
    .general_io_pin_2_in(p_in[2]), .general_io_pin_2_out(p_out[2]), .general_io_pin_2_oe(p_oe[2]),
    .general_io_pin_3_in(p_in[3]), .general_io_pin_3_out(p_out[3]), .general_io_pin_3_oe(p_oe[3]),
    .sec_clock_output_0(sclk[0]), .sec_clock_output_1(sclk[1]), .sec_clock_output_2(sclk[2]),
    .sec_clock_output_3(sclk[3]), .sec_clock_output_4(sclk[4]), .sec_clock_output_5(sclk[5]),
    .sec_clock_output_6(sclk[6]), .sec_clock_output_7(sclk[7]), .sec_clock_output_8(sclk[8]),
    .sec_clock_output_9(sclk[9]), .dread_timeout_evt(evt[5]), .dwrite_timeout_evt(evt[4]),
    .pw_master_abort_evt(evt[3]), .pw_target_abort_evt(evt[2]), .pw_timeout_evt(evt[1]),
    .pw_parity_evt(evt[0])
  );
  board_model board_u (.dev_out(p_out), .dev_oe(p_oe), .board_lvl(board_lvl), .pin_level(p_in));

  // 40 MHz core clock
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle write strobe; the reference model follows the same write
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    model_wr(a, d);
  endtask

  // write then read back with no idle cycle between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [15:0] d, input logic [15:0] exp);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    model_wr(a, d);
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk($sformatf("echo %h", a), exp, reg_rdata);
  endtask

  // reference register model, written from the rules
  task automatic model_wr(input logic [7:0] a, input logic [15:0] d);
    case (a)
      OFS_DRIVE: begin
        m_drive = d[7:0];
        m_lvl = (m_lvl | d[7:4]) & ~d[3:0];
      end
      OFS_DIR: begin
        m_dir = d[7:0];
        m_oe = (m_oe | d[7:4]) & ~d[3:0];
      end
      OFS_CLKGATE: m_gate = d & CLKGATE_WMASK;
      OFS_CAUSE: m_cause = m_cause & ~d[7:0];
      OFS_CAUSE_MASK: m_mask = d[7:0] & 8'h7e;
      default: ;
    endcase
  endtask

  // read data only stand in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk($sformatf("reg %h", a), exp, reg_rdata);
  endtask

  task automatic chk_pins();
    @(posedge core_clk);
    @(negedge core_clk);
    chk("pin oe", {12'h0, m_oe}, {12'h0, p_oe});
    chk("pin out", {12'h0, m_oe & m_lvl}, {12'h0, p_out});
  endtask

  // stopped outputs sit high; running ones change every cycle
  task automatic chk_clocks();
    logic [9:0] a;
    logic [9:0] stop;
    for (int i = 0; i < 10; i++) begin
      stop[i] = (i >= 4) ? m_gate[i + 4] : &m_gate[2 * i +: 2];
    end
    @(negedge core_clk);
    a = sclk;
    @(negedge core_clk);
    chk("clk stopped", {6'h0, stop}, {6'h0, stop & a & sclk});
    chk("clk running", {6'h0, ~stop}, {6'h0, ~stop & (a ^ sclk)});
  endtask

  task automatic chk_irq();
    @(posedge core_clk);
    @(negedge core_clk);
    chk("irq", {15'h0, |(m_cause & m_mask)}, {15'h0, irq});
  endtask

  task automatic chk_reset();
    m_lvl = 4'h0;
    m_oe = 4'h0;
    m_drive = 8'h00;
    m_dir = 8'h00;
    m_gate = 16'h0000;
    m_cause = 8'h00;
    m_mask = 8'h00;
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    rd(OFS_DRIVE, 16'h0000);
    rd(OFS_DIR, 16'h0000);
    rd(OFS_CLKGATE, 16'h0000);
    rd(OFS_CAUSE, 16'h0000);
    rd(8'h70, 16'h0000);
    rd(OFS_PINS, {8'h0, board_lvl, 4'h0});
    chk_pins();
    chk_clocks();
    chk_irq();
    $display("test reset done");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // a hang costs a mismatch and ends the run the normal way
  initial begin
    #200000;
    failures++;
    print_verdict();
  end

  initial begin
    void'($urandom(19));
    chk_reset();
    // fixed corner values first, then random drive and direction writes
    for (int n = 0; n < 24; n++) begin
      wr(n[0] ? OFS_DRIVE : OFS_DIR, (n < 6) ? {8'h0, edge_v[n]} : 16'($urandom()));
      board_lvl <= 4'($urandom());
      chk_pins();
      rd(OFS_DRIVE, {8'h0, m_drive});
      rd(OFS_DIR, {8'h0, m_dir});
      repeat (6) @(posedge core_clk);
      rd(OFS_PINS, {8'h0, (m_oe & m_lvl) | (~m_oe & board_lvl), 4'h0});
    end
    wr_rd(OFS_DRIVE, 16'h00c3, 16'h00c3);
    chk_pins();
    $display("test pins done");
    for (int n = 0; n < 8; n++) begin
      wr(OFS_CLKGATE, (n == 0) ? 16'hffff : (n == 1) ? 16'h00e4 : 16'($urandom()));
      chk_clocks();
      rd(OFS_CLKGATE, m_gate);
    end
    $display("test clocks done");
    wr(OFS_CAUSE_MASK, 16'h002a);
    // each event sets its own bit and earlier bits stay
    for (int k = 0; k < 6; k++) begin
      @(posedge core_clk);
      evt <= 6'(1 << k);
      @(posedge core_clk);
      evt <= 6'h00;
      m_cause[k + 1] = 1'b1;
      chk_irq();
      rd(OFS_CAUSE, {8'h0, m_cause});
    end
    wr(OFS_CAUSE, 16'h0000);
    rd(OFS_CAUSE, {8'h0, m_cause});
    wr(OFS_CAUSE, 16'h002b);
    rd(OFS_CAUSE, {8'h0, m_cause});
    chk_irq();
    wr(OFS_CAUSE, 16'h00ff);
    chk_irq();
    // an event in the very cycle of its own clear must survive
    @(posedge core_clk);
    evt <= 6'h21;
    reg_wr <= 1'b1;
    reg_addr <= OFS_CAUSE;
    reg_wdata <= 16'h0042;
    @(posedge core_clk);
    evt <= 6'h00;
    reg_wr <= 1'b0;
    m_cause = 8'h42;
    chk_irq();
    rd(OFS_CAUSE, {8'h0, m_cause});
    $display("test cause done");
    // reset in mid-run with everything configured
    wr(OFS_DIR, 16'h00f0);
    wr(OFS_CLKGATE, 16'h3fff);
    rstn <= 1'b0;
    chk_reset();
    print_verdict();
  end
endmodule
`default_nettype wire
